// >>> mcsid_pkg.sv
// Constants, types and byte-sum helpers for the checksum and identification block
package mcsid_pkg;

  // ----------------------------------------------------------------
  // Register indices and byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] IDX_PART_ID = 32'h00ff0000;
  localparam logic [31:0] IDX_SILICON_REV = 32'h00ff0002;
  localparam logic [31:0] ADDR_PART_ID = IDX_PART_ID << 2;
  localparam logic [31:0] ADDR_SILICON_REV = IDX_SILICON_REV << 2;
  localparam logic [31:0] ADDR_CTRL = 32'h00000000;
  localparam logic [31:0] ADDR_LAST_CODE = 32'h00000004;
  localparam logic [31:0] ADDR_STATUS = 32'h00000008;
  localparam logic [31:0] ADDR_RESULT = 32'h0000000c;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int CTRL_START_BIT = 0;
  localparam int CTRL_VARIANT_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_PROT_BIT = 2;
  localparam logic [23:0] LAST_CODE_RST = 24'h002bfa;
  localparam logic [23:0] CODE_ADDR_STEP = 24'h000002;
  localparam logic [23:0] CODE_ADDR_FIRST = 24'h000000;

  // ----------------------------------------------------------------
  // Configuration masks
  // ----------------------------------------------------------------
  localparam logic [15:0] FIRST_CFG_MASK = 16'h3fff;
  localparam logic [15:0] SECOND_CFG_MASK = 16'hffff;
  localparam logic [7:0] DEBUG_MASK = 8'ha3;
  localparam logic [7:0] WATCHDOG_MASK = 8'hbf;
  localparam logic [7:0] OSC_MASK = 8'he7;
  localparam logic [7:0] OSC_SELECT_MASK = 8'h87;
  localparam logic [7:0] SEGMENT_MASK = 8'h03;

  // ----------------------------------------------------------------
  // Bus encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;

  typedef enum logic [1:0] {MCS_IDLE, MCS_CFG, MCS_FETCH} mcsid_state_t;

  // Sum of the three bytes of one code word, no phantom byte
  function automatic logic [15:0] mcsid_sum3(input logic [23:0] w);
    mcsid_sum3 = {8'h00, w[7:0]} + {8'h00, w[15:8]} + {8'h00, w[23:16]};
  endfunction : mcsid_sum3

  // Sum of the low two bytes only, upper byte dropped
  function automatic logic [15:0] mcsid_sum2(input logic [15:0] w);
    mcsid_sum2 = {8'h00, w[7:0]} + {8'h00, w[15:8]};
  endfunction : mcsid_sum2

endpackage : mcsid_pkg

// >>> mcsid_top.sv
// Code memory checksum engine with read-only identification words on AHB-Lite
`timescale 1ns/1ps
`default_nettype none
module mcsid_top
  import mcsid_pkg::*;
#(
  parameter logic [15:0] PART_ID = 16'h5a5a, // Arbitrary value
  parameter logic [15:0] SILICON_REV = 16'h0001 // Arbitrary value
) (
  input wire logic CLK_I,
  input wire logic ARST_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic READ_PROTECT_I,
  input wire logic [23:0] FIRST_CONFIG_WORD_I,
  input wire logic [23:0] SECOND_CONFIG_WORD_I,
  input wire logic [7:0] DEBUG_CONFIG_BYTE_I,
  input wire logic [7:0] WATCHDOG_CONFIG_BYTE_I,
  input wire logic [7:0] OSCILLATOR_CONFIG_BYTE_I,
  input wire logic [7:0] OSCILLATOR_SELECT_CONFIG_BYTE_I,
  input wire logic [7:0] SEGMENT_PROTECT_CONFIG_BYTE_I,
  output logic MEM_REQ_O,
  output logic [23:0] MEM_ADDR_O,
  input wire logic [23:0] MEM_DATA_I,
  input wire logic MEM_ACK_I
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  // Two-stage release; assertion stays asynchronous
  always_ff @(posedge CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic dp_write;
  logic [31:0] dp_addr;
  logic [31:0] hrdata;
  logic next_dp_write;
  logic [31:0] next_dp_addr;
  logic [31:0] next_hrdata;
  logic addr_take;
  logic wr_strobe;
  logic variant;
  logic [23:0] last_code;
  logic done;
  logic [15:0] result;
  logic [15:0] sum;
  mcsid_state_t state;

  assign addr_take = HSEL_I && HTRANS_I == HTRANS_NONSEQ && HREADY_I;
  assign wr_strobe = dp_write && HREADY_I;

  // Read data is formed at the address phase so it stands through the data phase
  always_comb begin
    next_dp_write = 1'b0;
    next_dp_addr = dp_addr;
    next_hrdata = 32'h00000000;
    if (addr_take) begin
      next_dp_write = HWRITE_I;
      next_dp_addr = HADDR_I;
      if (!HWRITE_I) begin
        case (HADDR_I)
          ADDR_PART_ID: next_hrdata = {16'h0000, PART_ID};
          ADDR_SILICON_REV: next_hrdata = {16'h0000, SILICON_REV};
          ADDR_CTRL: next_hrdata = {30'h00000000, variant, 1'b0};
          ADDR_LAST_CODE: next_hrdata = {8'h00, last_code};
          ADDR_STATUS: begin
            next_hrdata[STAT_BUSY_BIT] = state != MCS_IDLE;
            next_hrdata[STAT_DONE_BIT] = done;
            next_hrdata[STAT_PROT_BIT] = READ_PROTECT_I;
          end
          ADDR_RESULT: next_hrdata = {16'h0000, result};
          default: next_hrdata = 32'h00000000;
        endcase
      end
    end
  end

  // Zero wait states, always OKAY
  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_addr <= 32'h00000000;
      hrdata <= 32'h00000000;
      HREADYOUT_O <= 1'b0;
      HRESP_O <= 1'b0;
    end else begin
      dp_write <= next_dp_write;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      HREADYOUT_O <= 1'b1;
      HRESP_O <= 1'b0;
    end
  end
  assign HRDATA_O = hrdata;

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic start;
  logic next_variant;
  logic next_start;
  logic [23:0] next_last_code;

  // Identification addresses have no write path at all
  always_comb begin
    next_variant = variant;
    next_last_code = last_code;
    next_start = 1'b0;
    if (wr_strobe) begin
      case (dp_addr)
        ADDR_CTRL: begin
          next_variant = HWDATA_I[CTRL_VARIANT_BIT];
          next_start = HWDATA_I[CTRL_START_BIT];
        end
        ADDR_LAST_CODE: next_last_code = HWDATA_I[23:0];
        default: next_start = 1'b0;
      endcase
    end
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      variant <= 1'b0;
      last_code <= LAST_CODE_RST;
      start <= 1'b0;
    end else begin
      variant <= next_variant;
      last_code <= next_last_code;
      start <= next_start;
    end
  end

  // ----------------------------------------------------------------
  // Checksum sequencer
  // ----------------------------------------------------------------
  logic [15:0] cfg_gp_sum;
  logic [15:0] cfg_pc_sum;
  logic [23:0] code_word;
  mcsid_state_t next_state;
  logic [15:0] next_sum;
  logic [15:0] next_result;
  logic next_done;
  logic next_req;
  logic [23:0] next_mem_addr;

  // Config block sums; upper byte of each config word never enters
  assign cfg_gp_sum = mcsid_sum2(FIRST_CONFIG_WORD_I[15:0] & FIRST_CFG_MASK)
                    + mcsid_sum2(SECOND_CONFIG_WORD_I[15:0] & SECOND_CFG_MASK);
  assign cfg_pc_sum = {8'h00, DEBUG_CONFIG_BYTE_I & DEBUG_MASK}
                    + {8'h00, WATCHDOG_CONFIG_BYTE_I & WATCHDOG_MASK}
                    + {8'h00, OSCILLATOR_CONFIG_BYTE_I & OSC_MASK}
                    + {8'h00, OSCILLATOR_SELECT_CONFIG_BYTE_I & OSC_SELECT_MASK}
                    + {8'h00, SEGMENT_PROTECT_CONFIG_BYTE_I & SEGMENT_MASK};
  // Protected code reads as zero words
  assign code_word = READ_PROTECT_I ? 24'h000000 : MEM_DATA_I;

  // Request drops for a cycle after each ack so every address is a fresh handshake
  always_comb begin
    next_state = state;
    next_sum = sum;
    next_result = result;
    next_done = done;
    next_req = MEM_REQ_O;
    next_mem_addr = MEM_ADDR_O;
    case (state)
      MCS_IDLE: begin
        if (start) begin
          next_done = 1'b0;
          next_state = MCS_CFG;
        end
      end
      MCS_CFG: begin
        // Protection zeroes the whole result, config block included
        if (READ_PROTECT_I) begin
          next_sum = 16'h0000;
        end else begin
          next_sum = variant ? cfg_pc_sum : cfg_gp_sum;
        end
        next_mem_addr = CODE_ADDR_FIRST;
        next_req = 1'b1;
        next_state = MCS_FETCH;
      end
      MCS_FETCH: begin
        if (MEM_REQ_O && MEM_ACK_I) begin
          next_sum = sum + mcsid_sum3(code_word);
          next_req = 1'b0;
          if (MEM_ADDR_O == last_code) begin
            next_result = sum + mcsid_sum3(code_word);
            next_done = 1'b1;
            next_state = MCS_IDLE;
          end else begin
            next_mem_addr = MEM_ADDR_O + CODE_ADDR_STEP;
          end
        end else if (!MEM_REQ_O) begin
          next_req = 1'b1;
        end
      end
      default: next_state = MCS_IDLE;
    endcase
  end

  always_ff @(posedge CLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state <= MCS_IDLE;
      sum <= 16'h0000;
      result <= 16'h0000;
      done <= 1'b0;
      MEM_REQ_O <= 1'b0;
      MEM_ADDR_O <= CODE_ADDR_FIRST;
    end else begin
      state <= next_state;
      sum <= next_sum;
      result <= next_result;
      done <= next_done;
      MEM_REQ_O <= next_req;
      MEM_ADDR_O <= next_mem_addr;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!rst_n);

  sequence s_id_read;
    addr_take && !HWRITE_I && HADDR_I == ADDR_PART_ID;
  endsequence
  sequence s_start_walk;
    state == MCS_IDLE && start ##1 state == MCS_CFG ##1 state == MCS_FETCH && MEM_REQ_O;
  endsequence
  sequence s_last_ack;
    state == MCS_FETCH && MEM_REQ_O && MEM_ACK_I && MEM_ADDR_O == last_code;
  endsequence

  a_part_id_read: assert property (s_id_read |=> HRDATA_O == {16'h0000, PART_ID})
    else $error("part identifier read back wrong");
  a_rev_read: assert property (addr_take && !HWRITE_I && HADDR_I == ADDR_SILICON_REV
    |=> HRDATA_O[15:0] == SILICON_REV)
    else $error("silicon revision read back wrong");
  a_id_protect_read: assert property (s_id_read and READ_PROTECT_I
    |=> HRDATA_O[15:0] != 16'h0000 || PART_ID == 16'h0000)
    else $error("identification blocked under protection");
  a_walk_start: assert property (s_start_walk |-> MEM_ADDR_O == CODE_ADDR_FIRST)
    else $error("code walk does not start at first address");
  a_cfg_general: assert property (state == MCS_CFG && !variant && !READ_PROTECT_I
    |=> sum == $past(cfg_gp_sum))
    else $error("general config block sum wrong");
  a_cfg_power: assert property (state == MCS_CFG && variant && !READ_PROTECT_I
    |=> sum == $past(cfg_pc_sum))
    else $error("power config block sum wrong");
  a_protect_zero: assert property ((s_last_ack and (READ_PROTECT_I && $past(READ_PROTECT_I, 2)
    && sum == 16'h0000)) |=> result == 16'h0000 && done)
    else $error("protected checksum not zero");
  a_code_bytes: assert property (state == MCS_FETCH && MEM_REQ_O && MEM_ACK_I
    && !READ_PROTECT_I |=> sum == 16'($past(sum) + {8'h00, $past(MEM_DATA_I[7:0])}
    + {8'h00, $past(MEM_DATA_I[15:8])} + {8'h00, $past(MEM_DATA_I[23:16])}))
    else $error("code word bytes not added");
  a_last_inclusive: assert property (s_last_ack |=> state == MCS_IDLE && done
    && result == sum)
    else $error("walk did not end on last address");
  a_walk_step: assert property (state == MCS_FETCH && MEM_REQ_O && MEM_ACK_I
    && MEM_ADDR_O != last_code |=> !MEM_REQ_O ##1 MEM_REQ_O
    && MEM_ADDR_O == $past(MEM_ADDR_O, 2) + CODE_ADDR_STEP)
    else $error("code address step wrong");
  // Ready only rises one edge after the reset copy, so skip that first edge
  a_bus_okay: assert property ($past(rst_n) |-> HREADYOUT_O && !HRESP_O)
    else $error("bus answer not ready or not okay");

endmodule : mcsid_top
`default_nettype wire

// >>> mcsid_mem_model.sv
// Behavioural code memory readout facing the checksum engine
`timescale 1ns/1ps
`default_nettype none
module mcsid_mem_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic [23:0] addr_i,
  input wire logic fill_i,
  input wire logic [3:0] lat_i,
  output logic ack_o,
  output logic [23:0] data_o,
  output logic [15:0] acks_o,
  output logic [23:0] last_o
);
  logic [3:0] wait_cnt;
  initial begin
    ack_o = 1'b0;
    data_o = 24'h000000;
    acks_o = 16'h0000;
    last_o = 24'h000000;
    wait_cnt = 4'h0;
  end
  // Answer after lat_i extra cycles; data toggles outside the ack cycle
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    data_o <= ~data_o; // A stale word must never look valid
    if (req_i && !ack_o) begin
      if (wait_cnt >= lat_i) begin
        ack_o <= 1'b1;
        data_o <= fill_i ? 24'hffffff : {addr_i[7:0] ^ 8'h3c, 8'h81, addr_i[7:0]};
        acks_o <= acks_o + 16'h0001;
        last_o <= addr_i;
        wait_cnt <= 4'h0;
      end else begin
        wait_cnt <= wait_cnt + 4'h1;
      end
    end
  end
endmodule : mcsid_mem_model
`default_nettype wire

// >>> memory_checksum_id_readout_bench.sv
// Self-checking bench for the checksum engine and identification words
`timescale 1ns/1ps
`default_nettype none
module memory_checksum_id_readout_bench;
  import mcsid_pkg::*;
  logic clk, arst_n, hsel, hwrite, hreadyout, hresp, prot, fill, req, ack;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [23:0] cfg1, cfg2, maddr, mdata, mlast;
  logic [7:0] dbg, wdg, osc, oscs, seg;
  logic [15:0] acks;
  logic [3:0] lat;
  int num_errors = 0;
  int cmp_count = 0;
  localparam logic [15:0] CFG_GEN = 16'h003f + 16'h00ff + 16'h0012 + 16'h0034;

  // Arbitrary identification values
  mcsid_top #(.PART_ID(16'h1234), .SILICON_REV(16'h0042)) i_dut (
    .CLK_I(clk), .ARST_N_I(arst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(HSIZE_WORD), .HWDATA_I(hwdata), .HREADY_I(hreadyout),
    .HRDATA_O(hrdata), .HREADYOUT_O(hreadyout), .HRESP_O(hresp), .READ_PROTECT_I(prot),
    .FIRST_CONFIG_WORD_I(cfg1), .SECOND_CONFIG_WORD_I(cfg2), .DEBUG_CONFIG_BYTE_I(dbg),
    .WATCHDOG_CONFIG_BYTE_I(wdg), .OSCILLATOR_CONFIG_BYTE_I(osc),
    .OSCILLATOR_SELECT_CONFIG_BYTE_I(oscs), .SEGMENT_PROTECT_CONFIG_BYTE_I(seg),
    .MEM_REQ_O(req), .MEM_ADDR_O(maddr), .MEM_DATA_I(mdata), .MEM_ACK_I(ack));

  mcsid_mem_model i_mem (.clk_i(clk), .req_i(req), .addr_i(maddr), .fill_i(fill),
    .lat_i(lat), .ack_o(ack), .data_o(mdata), .acks_o(acks), .last_o(mlast));

  // ----------------------------------------------------------------
  // Bus and checking helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish;
    if (num_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, seen);
    end
  endtask : chk

  // Ends at the falling edge just before the edge that sees ready high
  task automatic wait_rdy;
    int n;
    n = 0;
    @(negedge clk);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 100) begin
        num_errors++;
        tally_and_finish;
      end
      @(negedge clk);
    end
  endtask : wait_rdy

  task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] wd,
                     output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= HTRANS_NONSEQ;
    wait_rdy;
    @(posedge clk);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    wait_rdy;
    r = hrdata; // Value as it stands at the sampling edge
    @(posedge clk);
  endtask : bus

  task automatic wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    bus(1'b1, a, d, dummy);
  endtask : wr

  task automatic rd(input logic [31:0] a, output logic [31:0] r);
    bus(1'b0, a, 32'h0, r);
  endtask : rd

  // Independent model of the code byte sum, mod 65536
  function automatic logic [15:0] code_sum(input logic [23:0] last, input logic f);
    logic [15:0] s;
    logic [23:0] w;
    s = 16'h0000;
    for (int a = 0; a <= int'(last); a += 2) begin
      w = f ? 24'hffffff : {a[7:0] ^ 8'h3c, 8'h81, a[7:0]};
      s = s + w[7:0] + w[15:8] + w[23:16];
    end
    return s;
  endfunction : code_sum

  task automatic checksum_run(input logic v, input logic [23:0] last, input logic [15:0] exp);
    logic [31:0] d;
    logic [15:0] a0;
    int n;
    a0 = acks;
    n = 0;
    d = 32'h0;
    wr(ADDR_LAST_CODE, {8'h00, last});
    wr(ADDR_CTRL, {30'h0, v, 1'b1});
    // A read right behind the start write still shows the previous run's done flag
    rd(ADDR_STATUS, d);
    rd(ADDR_STATUS, d);
    chk("busy after start", {31'h0, d[STAT_BUSY_BIT]}, 32'h1);
    while (d[STAT_DONE_BIT] !== 1'b1) begin
      rd(ADDR_STATUS, d);
      n++;
      if (n > 3000) begin
        num_errors++;
        tally_and_finish;
      end
    end
    rd(ADDR_RESULT, d);
    chk("result", d, {16'h0000, exp});
    chk("word count", {16'h0000, acks - a0}, {9'h000, last[23:1] + 23'h1});
    chk("last address", {8'h00, mlast}, {8'h00, last});
  endtask : checksum_run

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic t_ids;
    logic [31:0] d;
    rd(ADDR_PART_ID, d);
    chk("part id", d, 32'h00001234);
    wr(ADDR_SILICON_REV, 32'hffffffff);
    rd(ADDR_SILICON_REV, d);
    chk("revision after write", d, 32'h00000042);
    prot <= 1'b1;
    rd(ADDR_PART_ID, d);
    chk("part id protected", d, 32'h00001234);
    rd(ADDR_STATUS, d);
    chk("protect flag", {29'h0, d[2:0]}, 32'h1 << STAT_PROT_BIT);
    prot <= 1'b0;
    rd(32'h00000100, d);
    chk("unmapped", d, 32'h0);
    rd(ADDR_LAST_CODE, d);
    chk("last code reset", d, {8'h00, LAST_CODE_RST});
  endtask : t_ids

  task automatic t_general;
    cfg1 <= 24'hc5ffff; // Upper byte and bits 15:14 must vanish
    cfg2 <= 24'h7e1234;
    lat <= 4'h3;
    checksum_run(1'b0, 24'h000006, CFG_GEN + code_sum(24'h6, 1'b0));
  endtask : t_general

  task automatic t_power;
    {dbg, wdg, osc, oscs, seg} <= {5{8'hff}};
    lat <= 4'h0;
    // All-ones bytes leave only the masks: a3 + bf + e7 + 87 + 03
    checksum_run(1'b1, 24'h000008, 16'h02d3 + code_sum(24'h8, 1'b0));
  endtask : t_power

  task automatic t_wrap;
    fill <= 1'b1;
    lat <= 4'h1;
    checksum_run(1'b0, 24'h0000aa, CFG_GEN + code_sum(24'haa, 1'b1));
    fill <= 1'b0;
  endtask : t_wrap

  task automatic t_protect;
    prot <= 1'b1;
    checksum_run(1'b0, 24'h000004, 16'h0000);
    prot <= 1'b0;
  endtask : t_protect

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Main sequence: reset, then every scenario once
  initial begin
    {arst_n, hsel, hwrite, prot, fill, htrans, lat} = '0;
    {haddr, hwdata, cfg1, cfg2, dbg, wdg, osc, oscs, seg} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    wait_rdy;
    @(posedge clk);
    t_ids;
    t_general;
    t_power;
    t_wrap;
    t_protect;
    tally_and_finish;
  end
endmodule : memory_checksum_id_readout_bench
`default_nettype wire
